/* File: metering_mode_control_regs_tb_top.sv */
`timescale 1ns/1ns
`include "mmc_defs.vh"

module metering_mode_control_regs_tb_top;
    `define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
    reg ref_clk = 0, ce = 1, rst = 1, hsel = 0, hwrite = 0, rms_rdy = 0, vzc = 0;
    reg [31:0] haddr = 0, hwdata = 0;
    reg [1:0] htrans = 0;
    reg [2:0] hsize = 3'h2;
    reg [3:0] cand = 0;
    reg [7:0] rv;
    wire hreadyout, hresp, p1, p2, sr, zcf, swp, pd, hpb, ch, fsel, wen, rms_upd;
    wire [31:0] hrdata;
    integer fail_count = 0, compares = 0, i, k;
    int ab[4] = '{6, 4, 3, 0};
    int bb[3] = '{3, 1, 0};

    always #2 ref_clk = ~ref_clk;

    mmc_regs uut (.REF_CLK(ref_clk), .CE(ce), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout),
        .HRESP(hresp), .HRDATA(hrdata), .ACTIVE_PULSE(cand[0]), .REACTIVE_PULSE(cand[1]),
        .APPARENT_PULSE(cand[2]), .IRMS_PULSE(cand[3]), .RMS_SAMPLE_READY(rms_rdy), .VOLT_ZERO_CROSS(vzc),
        .PULSE_OUTPUT_ONE(p1), .PULSE_OUTPUT_TWO(p2), .METERING_SOFT_RESET(sr), .ZERO_CROSS_FILTER_OFF(zcf),
        .ADC_CHANNEL_SWAP(swp), .ADC_POWER_DOWN(pd), .HIGHPASS_BYPASS(hpb), .APPARENT_OR_RMS_CHOICE(ch),
        .PERIOD_OR_FREQ_SELECT(fsel), .WAVEFORM_SAMPLE_ENABLE(wen), .RMS_UPDATE(rms_upd));

    // One single transfer; outputs are read just after an edge, so they show the pre-edge value
    task bus(input [9:0] idx, input w, input [7:0] d);
        begin
            hsel <= 1'b1;
            htrans <= 2'h2;
            haddr <= {20'h0, idx, 2'h0};
            hwrite <= w;
            @(posedge ref_clk);
            while (hreadyout !== 1'b1) @(posedge ref_clk);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= {24'h0, d};
            @(posedge ref_clk);
            while (hreadyout !== 1'b1) @(posedge ref_clk);
            rv = hrdata[7:0];
        end
    endtask

    task pulse(input integer n);
        begin
            cand <= 4'h1 << n;
            @(posedge ref_clk);
            cand <= 4'h0;
            @(posedge ref_clk);
        end
    endtask

    function integer pick(input [1:0] s, input c);
        pick = s[1] ? (c ? 3 : 2) : s;
    endfunction

    task stop_test;
        begin
            $display("compares=%0d fail_count=%0d", compares, fail_count);
            if (fail_count == 0 && compares > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        stop_test;
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        bus(`MMC_IDX_CTRL_A, 0, 0);
        `CHK(rv, 8'h06)
        bus(`MMC_IDX_CTRL_B, 0, 0);
        `CHK(rv, 8'h40)
        `CHK({sr, zcf, swp, pd, hpb, ch, fsel, wen, p1, p2, rms_upd}, 11'h0)
        for (i = 0; i < 4; i++) begin
            bus(`MMC_IDX_CTRL_A, 1, 8'h06 | (8'h1 << ab[i]));
            @(posedge ref_clk);
            `CHK({zcf, swp, pd, hpb}, 4'h8 >> i)
        end
        for (i = 0; i < 3; i++) begin
            bus(`MMC_IDX_CTRL_B, 1, 8'h40 | (8'h1 << bb[i]));
            bus(`MMC_IDX_CTRL_B, 0, 0);
            `CHK(rv, 8'h40 | (8'h1 << bb[i]))
            `CHK({ch, fsel, wen}, 3'h4 >> i)
        end
        bus(`MMC_IDX_CTRL_A, 1, 8'h00);
        for (i = 0; i < 8; i++) begin
            bus(`MMC_IDX_CTRL_B, 1, {~i[1:0], i[1:0], i[2], 3'h0});
            for (k = 0; k < 4; k++) begin
                pulse(k);
                `CHK(p1, k == pick(i[1:0], i[2]))
                `CHK(p2, k == pick(~i[1:0], i[2]))
            end
        end
        bus(`MMC_IDX_CTRL_B, 1, 8'h00);
        bus(`MMC_IDX_CTRL_A, 1, 8'h04);
        pulse(0);
        `CHK({p1, p2}, 2'h2)
        bus(`MMC_IDX_CTRL_A, 1, 8'h02);
        pulse(0);
        `CHK({p1, p2}, 2'h1)
        // A low clock enable must freeze the output and stall the bus
        ce <= 1'b0;
        pulse(0);
        `CHK({p1, p2, hreadyout}, 3'h0)
        ce <= 1'b1;
        rms_rdy <= 1'b1;
        @(posedge ref_clk);
        rms_rdy <= 1'b0;
        @(posedge ref_clk);
        `CHK(rms_upd, 1'b1)
        bus(`MMC_IDX_CTRL_B, 1, 8'h04);
        rms_rdy <= 1'b1;
        @(posedge ref_clk);
        rms_rdy <= 1'b0;
        repeat (3) @(posedge ref_clk);
        `CHK(rms_upd, 1'b0)
        bus(`MMC_IDX_STATUS, 0, 0);
        `CHK(rv, 8'h02)
        vzc <= 1'b1;
        @(posedge ref_clk);
        vzc <= 1'b0;
        @(posedge ref_clk);
        `CHK(rms_upd, 1'b1)
        // Soft reset with non-default contents; the write issued while busy must be dropped
        bus(`MMC_IDX_CTRL_B, 1, 8'h8f);
        bus(`MMC_IDX_CTRL_A, 1, 8'h9f);
        @(posedge ref_clk);
        `CHK(sr, 1'b1)
        bus(`MMC_IDX_CTRL_B, 1, 8'h00);
        bus(`MMC_IDX_STATUS, 0, 0);
        `CHK(rv, 8'h11)
        k = 0;
        while (sr === 1'b1 && k < 20) begin
            @(posedge ref_clk);
            k++;
        end
        bus(`MMC_IDX_CTRL_A, 0, 0);
        `CHK(rv, 8'h06)
        bus(`MMC_IDX_CTRL_B, 0, 0);
        `CHK(rv, 8'h40)
        bus(10'h100, 1, 8'hff);
        bus(10'h100, 0, 0);
        `CHK(rv, 8'h00)
        stop_test;
    end
endmodule

/* File: mmc_ahb_slave.v */
`timescale 1ns/1ns
`include "mmc_defs.vh"

module mmc_ahb_slave (
    // Clock and reset
    input wire clk,
    input wire rst,
    input wire ce,
    // AHB-Lite
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // Register side
    output wire wr_en,
    output wire [`MMC_IDX_W-1:0] reg_idx,
    output wire [7:0] wr_data,
    input wire [7:0] rd_data
);

    reg wr_phase;
    reg rd_phase;
    reg rd_done;
    reg [`MMC_IDX_W-1:0] idx;
    wire take;

    // Only whole-word transfers are expected; size is not checked
    assign take = hsel & htrans[`MMC_HTRANS_NONSEQ_BIT] & hready;
    assign wr_en = wr_phase & ce;
    assign reg_idx = idx;
    assign wr_data = hwdata[7:0];
    assign hresp = `MMC_HRESP_OKAY;
    // One wait state on reads so a read always sees an earlier write;
    // a low clock enable stalls the bus so no transfer is lost while frozen
    assign hreadyout = ce & ~(rd_phase & ~rd_done);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_phase <= 1'b0;
            rd_phase <= 1'b0;
            rd_done <= 1'b0;
            idx <= {`MMC_IDX_W{1'b0}};
            hrdata <= 32'h0;
        end else if (ce) begin
            if (rd_phase & ~rd_done) begin
                rd_done <= 1'b1;
                hrdata <= {24'h0, rd_data};
            end else begin
                rd_done <= 1'b0;
                wr_phase <= take & hwrite;
                rd_phase <= take & ~hwrite;
                if (take) begin
                    // Out-of-window addresses map to an unused index
                    idx <= (haddr[31:10] == 22'h0) ? haddr[9:2] : {`MMC_IDX_W{1'b1}};
                end
            end
        end
    end

endmodule

/* File: mmc_defs.vh */
`ifndef MMC_DEFS_VH
`define MMC_DEFS_VH

// Register indices; byte address is four times the index
`define MMC_IDX_CTRL_A 8'h0b
`define MMC_IDX_CTRL_B 8'h0c
`define MMC_IDX_STATUS 8'h40
`define MMC_IDX_W 8

// Reset values
`define MMC_CTRL_A_RST 8'h06
`define MMC_CTRL_B_RST 8'h40

// Control register A fields
`define MMC_A_SOFT_RESET 7
`define MMC_A_ZX_FILTER_OFF 6
`define MMC_A_RESERVED 5
`define MMC_A_CH_SWAP 4
`define MMC_A_POWER_DOWN 3
`define MMC_A_PULSE_TWO_OFF 2
`define MMC_A_PULSE_ONE_OFF 1
`define MMC_A_HP_BYPASS 0

// Control register B fields
`define MMC_B_TWO_SRC_HI 7
`define MMC_B_TWO_SRC_LO 6
`define MMC_B_ONE_SRC_HI 5
`define MMC_B_ONE_SRC_LO 4
`define MMC_B_RMS_CHOICE 3
`define MMC_B_RMS_ON_ZX 2
`define MMC_B_FREQ_SEL 1
`define MMC_B_WAVE_EN 0

// Pulse source field and effective source codes
`define MMC_SRC_ACTIVE 2'h0
`define MMC_SRC_REACTIVE 2'h1
`define MMC_SRC_APPARENT 2'h2
`define MMC_SRC_IRMS 2'h3

// Status register fields
`define MMC_S_BUSY 0
`define MMC_S_RMS_PEND 1
`define MMC_S_ONE_LO 2
`define MMC_S_TWO_LO 4

// Soft reset hold time
`define MMC_CLK_NS 4
`define MMC_SOFT_RESET_NS 20
`define MMC_SOFT_RESET_CYC ((`MMC_SOFT_RESET_NS + `MMC_CLK_NS - 1) / `MMC_CLK_NS)
`define MMC_CNT_W 4

// AHB-Lite encodings
`define MMC_HTRANS_NONSEQ_BIT 1
`define MMC_HRESP_OKAY 1'h0

`endif

/* File: mmc_pulse_route.v */
`timescale 1ns/1ns
`include "mmc_defs.vh"

module mmc_pulse_route (
    // Clock and reset
    input wire clk,
    input wire rst,
    input wire ce,
    // Selection
    input wire [1:0] source,
    input wire rms_choice,
    input wire disable_out,
    // Candidate pulse strobes
    input wire active_pulse,
    input wire reactive_pulse,
    input wire apparent_pulse,
    input wire irms_pulse,
    // Result
    output wire [1:0] effective,
    output reg pulse
);

    reg next_pulse;

    assign effective = source[1] ? (rms_choice ? `MMC_SRC_IRMS : `MMC_SRC_APPARENT) : source;

    always @* begin
        case (effective)
            `MMC_SRC_ACTIVE: next_pulse = active_pulse;
            `MMC_SRC_REACTIVE: next_pulse = reactive_pulse;
            `MMC_SRC_APPARENT: next_pulse = apparent_pulse;
            default: next_pulse = irms_pulse;
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pulse <= 1'b0;
        end else if (ce) begin
            pulse <= next_pulse & ~disable_out;
        end
    end

endmodule

/* File: mmc_regs.v */
`timescale 1ns/1ns
`include "mmc_defs.vh"

// How it works
// - Writing 1 to the soft reset bit returns every metering register to its default value.
// - The zero-crossing filter off bit bypasses the low-pass filter of zero-crossing detection and resets to 0.
// - The channel swap bit exchanges the roles of the two ADC channels.
// - The power down bit powers down both voltage and current converters.
// - The pulse output two off bit resets to 1 and holds pulse output two disabled while set.
// - The pulse output one off bit resets to 1 and holds pulse output one disabled while set.
// - The high-pass bypass bit bypasses the high-pass filters of both channels.
// - Bits 7 to 6 of control register B, reset 01, pick active, reactive, or apparent-or-rms for output two.
// - Bits 5 to 4 of control register B, reset 00, pick active, reactive, or apparent-or-rms for output one.
// - Bit 3 of control register B picks apparent power or current rms for any 1x output and the accumulators.
// - With bit 2 of control register B set, rms results update only at voltage zero-crossings.
// - Bit 1 of control register B makes the line result a period (0) or a frequency (1).
// - Bit 0 of control register B enables waveform sampling and resets to 0.
module mmc_regs (
    // Clock, enable and reset
    input wire REF_CLK,
    input wire CE,
    input wire RST,
    // AHB-Lite slave
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output wire HREADYOUT,
    output wire HRESP,
    output wire [31:0] HRDATA,
    // Pulse candidates from the datapath
    input wire ACTIVE_PULSE,
    input wire REACTIVE_PULSE,
    input wire APPARENT_PULSE,
    input wire IRMS_PULSE,
    // Rms and zero-crossing events
    input wire RMS_SAMPLE_READY,
    input wire VOLT_ZERO_CROSS,
    // Pulse outputs
    output wire PULSE_OUTPUT_ONE,
    output wire PULSE_OUTPUT_TWO,
    // Datapath controls
    output wire METERING_SOFT_RESET,
    output wire ZERO_CROSS_FILTER_OFF,
    output wire ADC_CHANNEL_SWAP,
    output wire ADC_POWER_DOWN,
    output wire HIGHPASS_BYPASS,
    output wire APPARENT_OR_RMS_CHOICE,
    output wire PERIOD_OR_FREQ_SELECT,
    output wire WAVEFORM_SAMPLE_ENABLE,
    output reg RMS_UPDATE
);

    // Soft reset sequencer states
    localparam ST_IDLE = 3'b001;
    localparam ST_HOLD = 3'b010;
    localparam ST_DONE = 3'b100;

    reg [7:0] metering_ctrl_a;
    reg [7:0] metering_ctrl_b;
    reg [2:0] state;
    reg [2:0] next_state;
    reg [`MMC_CNT_W-1:0] hold_cnt;
    reg [`MMC_CNT_W-1:0] next_hold_cnt;
    reg [7:0] next_ctrl_a;
    reg [7:0] next_ctrl_b;
    reg rms_pending;
    reg next_rms_pending;
    reg next_rms_update;
    reg [7:0] status;
    reg [7:0] rd_data;
    reg wr_a;
    reg wr_b;

    wire wr_en;
    wire [`MMC_IDX_W-1:0] reg_idx;
    wire [7:0] wr_data;
    wire soft_req;
    // Hold time in whole clocks, rounded up
    wire [31:0] hold_cyc = `MMC_SOFT_RESET_CYC;
    wire busy;
    wire [1:0] src [0:1];
    wire [1:0] eff [0:1];
    wire [1:0] off_bit;
    wire [1:0] pulse_out;

    // Bus front end; it stalls the bus while the clock enable is low
    mmc_ahb_slave u_bus (
        .clk(REF_CLK),
        .rst(RST),
        .ce(CE),
        .hsel(HSEL),
        .haddr(HADDR),
        .htrans(HTRANS),
        .hwrite(HWRITE),
        .hsize(HSIZE),
        .hwdata(HWDATA),
        .hready(HREADY),
        .hreadyout(HREADYOUT),
        .hresp(HRESP),
        .hrdata(HRDATA),
        .wr_en(wr_en),
        .reg_idx(reg_idx),
        .wr_data(wr_data),
        .rd_data(rd_data)
    );

    // Busy covers the hold and the closing done cycle
    assign busy = ~state[0];
    assign soft_req = wr_a & wr_data[`MMC_A_SOFT_RESET];

    // Write decode; writes are dropped while the metering reset runs,
    // so software polls the busy flag before it writes again
    always @* begin
        wr_a = 1'b0;
        wr_b = 1'b0;
        if (wr_en & ~busy) begin
            case (reg_idx)
                `MMC_IDX_CTRL_A: wr_a = 1'b1;
                `MMC_IDX_CTRL_B: wr_b = 1'b1;
                default: begin
                    wr_a = 1'b0;
                    wr_b = 1'b0;
                end
            endcase
        end
    end

    // Soft reset sequencer: hold, then one done cycle that clears the bit
    always @* begin
        case (state)
            ST_IDLE: next_state = soft_req ? ST_HOLD : ST_IDLE;
            ST_HOLD: next_state = (hold_cnt == `MMC_CNT_W'd1) ? ST_DONE : ST_HOLD;
            ST_DONE: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always @* begin
        next_hold_cnt = hold_cnt;
        if (soft_req) begin
            next_hold_cnt = hold_cyc[`MMC_CNT_W-1:0];
        end else if (state == ST_HOLD) begin
            next_hold_cnt = hold_cnt - `MMC_CNT_W'd1;
        end
    end

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state <= ST_IDLE;
            hold_cnt <= {`MMC_CNT_W{1'b0}};
        end else if (CE) begin
            state <= next_state;
            hold_cnt <= next_hold_cnt;
        end
    end

    // Control register A
    always @* begin
        next_ctrl_a = metering_ctrl_a;
        if (soft_req) begin
            next_ctrl_a = `MMC_CTRL_A_RST;
            next_ctrl_a[`MMC_A_SOFT_RESET] = 1'b1;
        end else if (state == ST_DONE) begin
            next_ctrl_a[`MMC_A_SOFT_RESET] = 1'b0;
        end else if (wr_a) begin
            // Reserved bit stored as written; software keeps it 0
            next_ctrl_a = wr_data;
        end
    end

    // Control register B
    always @* begin
        next_ctrl_b = metering_ctrl_b;
        if (soft_req) begin
            next_ctrl_b = `MMC_CTRL_B_RST;
        end else if (wr_b) begin
            next_ctrl_b = wr_data;
        end
    end

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            metering_ctrl_a <= `MMC_CTRL_A_RST;
            metering_ctrl_b <= `MMC_CTRL_B_RST;
        end else if (CE) begin
            metering_ctrl_a <= next_ctrl_a;
            metering_ctrl_b <= next_ctrl_b;
        end
    end

    // Status word: busy, held rms sample and the effective source of each output
    always @* begin
        status = 8'h0;
        status[`MMC_S_BUSY] = busy;
        status[`MMC_S_RMS_PEND] = rms_pending;
        status[`MMC_S_ONE_LO +: 2] = eff[0];
        status[`MMC_S_TWO_LO +: 2] = eff[1];
    end

    // Register read mux, sampled by the bus front end
    always @* begin
        rd_data = 8'h0;
        case (reg_idx)
            `MMC_IDX_CTRL_A: rd_data = metering_ctrl_a;
            `MMC_IDX_CTRL_B: rd_data = metering_ctrl_b;
            `MMC_IDX_STATUS: rd_data = status;
            default: rd_data = 8'h0;
        endcase
    end

    // Datapath controls; the reset pulse covers the whole hold
    assign METERING_SOFT_RESET = metering_ctrl_a[`MMC_A_SOFT_RESET];
    assign ZERO_CROSS_FILTER_OFF = metering_ctrl_a[`MMC_A_ZX_FILTER_OFF];
    assign ADC_CHANNEL_SWAP = metering_ctrl_a[`MMC_A_CH_SWAP];
    assign ADC_POWER_DOWN = metering_ctrl_a[`MMC_A_POWER_DOWN];
    assign HIGHPASS_BYPASS = metering_ctrl_a[`MMC_A_HP_BYPASS];
    assign APPARENT_OR_RMS_CHOICE = metering_ctrl_b[`MMC_B_RMS_CHOICE];
    assign PERIOD_OR_FREQ_SELECT = metering_ctrl_b[`MMC_B_FREQ_SEL];
    assign WAVEFORM_SAMPLE_ENABLE = metering_ctrl_b[`MMC_B_WAVE_EN];

    assign src[1] = metering_ctrl_b[`MMC_B_TWO_SRC_HI:`MMC_B_TWO_SRC_LO];
    assign src[0] = metering_ctrl_b[`MMC_B_ONE_SRC_HI:`MMC_B_ONE_SRC_LO];
    assign off_bit[0] = metering_ctrl_a[`MMC_A_PULSE_ONE_OFF];
    assign off_bit[1] = metering_ctrl_a[`MMC_A_PULSE_TWO_OFF];

    // One router per pulse output
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_pulse
            // One choice bit feeds both, so mixed use cannot occur
            mmc_pulse_route u_route (
                .clk(REF_CLK),
                .rst(RST),
                .ce(CE),
                .source(src[ch]),
                .rms_choice(metering_ctrl_b[`MMC_B_RMS_CHOICE]),
                .disable_out(off_bit[ch]),
                .active_pulse(ACTIVE_PULSE),
                .reactive_pulse(REACTIVE_PULSE),
                .apparent_pulse(APPARENT_PULSE),
                .irms_pulse(IRMS_PULSE),
                .effective(eff[ch]),
                .pulse(pulse_out[ch])
            );
        end
    endgenerate

    assign PULSE_OUTPUT_ONE = pulse_out[0];
    assign PULSE_OUTPUT_TWO = pulse_out[1];

    // Rms update gating; a new sample in the same cycle as a crossing still goes out
    always @* begin
        next_rms_update = 1'b0;
        next_rms_pending = 1'b0;
        if (busy) begin
            // Soft reset drops any held sample
            next_rms_update = 1'b0;
            next_rms_pending = 1'b0;
        end else if (metering_ctrl_b[`MMC_B_RMS_ON_ZX]) begin
            // Hold a sample until a voltage crossing releases it
            if (VOLT_ZERO_CROSS) begin
                next_rms_update = rms_pending | RMS_SAMPLE_READY;
            end else begin
                next_rms_pending = rms_pending | RMS_SAMPLE_READY;
            end
        end else begin
            next_rms_update = RMS_SAMPLE_READY;
        end
    end

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rms_pending <= 1'b0;
            RMS_UPDATE <= 1'b0;
        end else if (CE) begin
            rms_pending <= next_rms_pending;
            RMS_UPDATE <= next_rms_update;
        end
    end

endmodule

/* File: mmc_regs_asserts.sv */
`timescale 1ns/1ns

module mmc_regs_asserts (
    // Clock and reset
    input wire REF_CLK,
    input wire CE,
    input wire RST,
    // Bus
    input wire HSEL,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire HREADY,
    input wire HREADYOUT,
    input wire HRESP,
    input wire [31:0] HRDATA,
    // Datapath
    input wire ACTIVE_PULSE,
    input wire REACTIVE_PULSE,
    input wire APPARENT_PULSE,
    input wire IRMS_PULSE,
    input wire RMS_SAMPLE_READY,
    input wire VOLT_ZERO_CROSS,
    input wire PULSE_OUTPUT_ONE,
    input wire PULSE_OUTPUT_TWO,
    input wire METERING_SOFT_RESET,
    input wire ADC_POWER_DOWN,
    input wire HIGHPASS_BYPASS,
    input wire APPARENT_OR_RMS_CHOICE,
    input wire WAVEFORM_SAMPLE_ENABLE,
    input wire RMS_UPDATE
);
    default clocking @(posedge REF_CLK); endclocking
    // A frozen clock enable stalls every count, so checks are disabled and any attempt in flight is dropped while it is low
    default disable iff (RST || !CE);
    wire taken = HSEL && HTRANS[1] && HREADY;

    AST_READ_WAIT: assert property (taken && !HWRITE |=> !HREADYOUT ##1 HREADYOUT) // bus timing
        else $error("read wait state wrong");
    AST_WRITE_NOWAIT: assert property (taken && HWRITE |=> HREADYOUT) // bus timing
        else $error("write stalled");
    AST_OKAY: assert property (HRESP == 1'b0 && (HREADYOUT || HRDATA[31:8] == 24'h0)) // bus response
        else $error("bad response or data");
    AST_SOFT_LEN: assert property ($rose(METERING_SOFT_RESET) |-> METERING_SOFT_RESET[*5] ##[1:3] !METERING_SOFT_RESET)
        else $error("soft reset length wrong");
    AST_SOFT_DEFAULTS: assert property (METERING_SOFT_RESET && $past(METERING_SOFT_RESET) |->
        !ADC_POWER_DOWN && !HIGHPASS_BYPASS && !APPARENT_OR_RMS_CHOICE && !WAVEFORM_SAMPLE_ENABLE)
        else $error("controls not at default");
    AST_SOFT_PULSES_OFF: assert property (METERING_SOFT_RESET && $past(METERING_SOFT_RESET) |->
        !PULSE_OUTPUT_ONE && !PULSE_OUTPUT_TWO)
        else $error("pulse during soft reset");
    AST_RMS_CAUSE: assert property (RMS_UPDATE |-> $past(RMS_SAMPLE_READY) || $past(VOLT_ZERO_CROSS))
        else $error("rms update without cause");
    AST_ONE_SHARED: assert property (PULSE_OUTPUT_ONE && !$past(ACTIVE_PULSE) && !$past(REACTIVE_PULSE) |->
        $past(APPARENT_OR_RMS_CHOICE ? IRMS_PULSE : APPARENT_PULSE))
        else $error("output one wrong shared source");
    AST_TWO_SHARED: assert property (PULSE_OUTPUT_TWO && !$past(ACTIVE_PULSE) && !$past(REACTIVE_PULSE) |->
        $past(APPARENT_OR_RMS_CHOICE ? IRMS_PULSE : APPARENT_PULSE))
        else $error("output two wrong shared source");
endmodule

bind mmc_regs mmc_regs_asserts u_chk (.REF_CLK(REF_CLK), .CE(CE), .RST(RST), .HSEL(HSEL), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
    .ACTIVE_PULSE(ACTIVE_PULSE), .REACTIVE_PULSE(REACTIVE_PULSE), .APPARENT_PULSE(APPARENT_PULSE),
    .IRMS_PULSE(IRMS_PULSE), .RMS_SAMPLE_READY(RMS_SAMPLE_READY), .VOLT_ZERO_CROSS(VOLT_ZERO_CROSS),
    .PULSE_OUTPUT_ONE(PULSE_OUTPUT_ONE), .PULSE_OUTPUT_TWO(PULSE_OUTPUT_TWO),
    .METERING_SOFT_RESET(METERING_SOFT_RESET), .ADC_POWER_DOWN(ADC_POWER_DOWN), .HIGHPASS_BYPASS(HIGHPASS_BYPASS),
    .APPARENT_OR_RMS_CHOICE(APPARENT_OR_RMS_CHOICE), .WAVEFORM_SAMPLE_ENABLE(WAVEFORM_SAMPLE_ENABLE),
    .RMS_UPDATE(RMS_UPDATE));
